/* File: src/cipc_pkg.sv */
// constants shared by the interrupt priority controller files
// assumes one peripheral clock and a synchronous active-low reset
package cipc_pkg;

  // register indices; byte address is four times the index
  localparam logic [1:0] REG_CTRL_IDX   = 2'h0;
  localparam logic [1:0] REG_STATUS_IDX = 2'h1;
  localparam logic [1:0] REG_LAST_IDX   = 2'h2;
  localparam logic [1:0] REG_HIVEC_IDX  = 2'h3;

  // vector_control fields
  localparam int ROT_EN_BIT     = 0;
  localparam int COMPACT_BIT    = 5;
  localparam int REGION_SEL_BIT = 6;

  // executing_level_status fields
  localparam int LO_EX_BIT  = 0;
  localparam int HI_EX_BIT  = 1;
  localparam int NMI_EX_BIT = 7;

  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] LAST_RST  = 8'h00;
  localparam logic [7:0] HIVEC_RST = 8'h00;

  // compact table vectors
  localparam logic [7:0] CVEC_NMI = 8'h01;
  localparam logic [7:0] CVEC_HI  = 8'h02;
  localparam logic [7:0] CVEC_LO  = 8'h03;

  // protected-write window length in completed instructions
  localparam logic [2:0] CCP_WINDOW_INSNS = 3'h4;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;

endpackage

/* File: src/cipc_arb_if.sv */
// request and winner signals between the controller and its arbiter
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface cipc_arb_if #(
  parameter int NUM_SRC = 16
);
  logic [NUM_SRC-1:0] nmi_req;
  logic [NUM_SRC-1:0] norm_req;
  logic               rot_en;
  logic [7:0]         last_vec;
  logic               nmi_hit;
  logic [7:0]         nmi_vec;
  logic               norm_hit;
  logic [7:0]         norm_vec;

  modport ctl (
    output nmi_req,
    output norm_req,
    output rot_en,
    output last_vec,
    input  nmi_hit,
    input  nmi_vec,
    input  norm_hit,
    input  norm_vec
  );
  modport arb (
    input  nmi_req,
    input  norm_req,
    input  rot_en,
    input  last_vec,
    output nmi_hit,
    output nmi_vec,
    output norm_hit,
    output norm_vec
  );
endinterface

/* File: src/cipc_arbiter.sv */
// combinational winner pick for non-maskable and normal-level requests
// assumes source i owns vector i+1; vector 0 is never an interrupt
`timescale 1ns/10ps
module cipc_arbiter #(
  parameter int NUM_SRC = 16
) (
  cipc_arb_if.arb arb
);
  import cipc_pkg::*;

  logic       above_hit;
  logic [7:0] above_vec;
  logic [7:0] first_vec;

  // walk from the top so the lowest vector is assigned last and wins
  always_comb begin
    arb.nmi_hit = 1'b0;
    arb.nmi_vec = 8'h00;
    arb.norm_hit = 1'b0;
    above_hit = 1'b0;
    above_vec = 8'h00;
    first_vec = 8'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (arb.nmi_req[i]) begin
        arb.nmi_hit = 1'b1; // R5
        arb.nmi_vec = 8'(i + 1);
      end
      if (arb.norm_req[i]) begin
        arb.norm_hit = 1'b1;
        first_vec = 8'(i + 1); // R7
        if (!arb.rot_en || 8'(i + 1) > arb.last_vec) begin
          above_hit = 1'b1;
          above_vec = 8'(i + 1);
        end
      end
    end
    // nothing above the last served one: wrap, last served ranks lowest
    arb.norm_vec = above_hit ? above_vec : first_vec; // R9
  end

endmodule

/* File: src/cipc_ccp_window.sv */
// protected-write window opened by the change-protection unlock key
// assumes the core pulses unlock and insn_done for one clock each
`timescale 1ns/10ps
module cipc_ccp_window (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic unlock,
  input  wire logic insn_done,
  input  wire logic consume,
  output logic      open_ff
);
  import cipc_pkg::*;

  logic [2:0] left_ff;

  // window counts completed instructions, not clocks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      left_ff <= 3'h0;
    end else if (unlock) begin
      left_ff <= CCP_WINDOW_INSNS; // R14
    end else if (consume) begin
      left_ff <= 3'h0;
    end else if (insn_done && left_ff != 3'h0) begin
      left_ff <= left_ff - 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      open_ff <= 1'b0;
    end else if (unlock) begin
      open_ff <= 1'b1;
    end else if (consume || (insn_done && left_ff == 3'h1)) begin
      open_ff <= 1'b0;
    end
  end

endmodule

/* File: src/cipc_top.sv */
// interrupt priority controller with an AXI4-Lite register slave
// assumes irq_req, core signals and the bus all run on mclk
//
// How it works
// R1 - sources default normal; high_level_vector picks one high source
// R2 - high request preempts normal handler; normal resumes after high returns
// R3 - non-maskable taken regardless of global enable, which stays untouched
// R4 - nothing is granted while a non-maskable handler executes
// R5 - simultaneous non-maskable requests granted lowest vector first
// R6 - non-maskable set is a fixed parameter; source enables are outside
// R7 - rotation off: normal requests granted lowest vector first
// R8 - control bit 0 selects round-robin or fixed normal arbitration
// R9 - rotation on: last served normal vector ranks lowest next time
// R10 - last served register loads each normal grant while rotation is on; RW; resets zero
// R11 - after reset normal arbitration favours the lowest vector
// R12 - compact table bit 5: vectors 1, 2, 3 by class
// R13 - region bit 6: zero application start, one boot start
// R14 - protected bits writable only within four instructions of unlock
// R15 - protected write outside window answers okay, bit unchanged
// R16 - rotation bit writes always accepted
// R17 - status bit 7 set during non-maskable handler, cleared on return
// R18 - status bit 1 set during high handler, kept under preemption
// R19 - status bit 0 set during normal handler, kept under preemption
// R20 - high_level_vector zero disables the high level; resets zero
// R21 - after a grant or return one instruction completes first
// R22 - granting never changes the global enable; software sets it
// R23 - vector with ack strobe out; return clears highest executing flag
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
module cipc_top #(
  parameter int                NUM_SRC  = 16,
  parameter logic [NUM_SRC-1:0] NMI_MASK = '0,
  parameter int                ADDR_W   = 8
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // requests from peripherals, already gated by their own enables
  input  wire logic [NUM_SRC-1:0] irq_req,
  // core side
  input  wire logic               global_int_enable,
  input  wire logic               insn_done,
  input  wire logic               handler_return,
  input  wire logic               change_protection_unlock,
  output logic                    irq_ack_ff,
  output logic [7:0]              irq_vector_ff,
  output logic                    vector_region_select_ff,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import cipc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]        ctrl_ff;
  logic [7:0]        last_ff;
  logic [7:0]        hivec_ff;
  logic              nmi_ex_ff;
  logic              hi_ex_ff;
  logic              lo_ex_ff;
  logic              holdoff_ff;

  logic              aw_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              w_held_ff;
  logic [7:0]        wdata_ff;
  logic              wlane_ff;

  logic              wr_fire;
  logic              wr_hit;
  logic              wr_ctrl;
  logic              ccp_open;
  logic              rd_hit;
  logic [7:0]        rd_byte;
  logic [7:0]        status_val;

  logic [NUM_SRC-1:0] hi_sel;
  logic               hi_req;
  logic               can_take;
  logic               take_nmi;
  logic               take_hi;
  logic               take_lo;

  cipc_arb_if #(.NUM_SRC(NUM_SRC)) arb_bus ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // only the four word slots at the bottom are mapped
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] top;
    top = a >> 4;
    return (a[1:0] == 2'h0) && (top == '0);
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order; each is held
  // until both are present and the previous response is gone
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hit  = wr_fire && addr_mapped(awaddr_ff) && wlane_ff;
  assign wr_ctrl = wr_hit && (awaddr_ff[3:2] == REG_CTRL_IDX);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (!aw_held_ff && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (!w_held_ff && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // registers are one byte wide: only byte lane 0 carries a write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 8'h00;
      wlane_ff  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata[7:0];
      wlane_ff  <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // a refused protected write still answers okay
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(awaddr_ff) ? AXI_OKAY : AXI_DECERR; // R15
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign status_val = {nmi_ex_ff, 5'h00, hi_ex_ff, lo_ex_ff};
  assign rd_hit     = addr_mapped(s_axi_araddr);

  always_comb begin
    unique case (s_axi_araddr[3:2])
      REG_CTRL_IDX:   rd_byte = ctrl_ff;
      REG_STATUS_IDX: rd_byte = status_val;
      REG_LAST_IDX:   rd_byte = last_ff;
      REG_HIVEC_IDX:  rd_byte = hivec_ff;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? {24'h000000, rd_byte} : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  cipc_ccp_window u_ccp (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .unlock    (change_protection_unlock),
    .insn_done (insn_done),
    .consume   (wr_ctrl),
    .open_ff   (ccp_open)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff[ROT_EN_BIT] <= wdata_ff[ROT_EN_BIT]; // R8 R16
      if (ccp_open) begin
        ctrl_ff[COMPACT_BIT]    <= wdata_ff[COMPACT_BIT]; // R14
        ctrl_ff[REGION_SEL_BIT] <= wdata_ff[REGION_SEL_BIT]; // R14
      end
    end
  end

  // a normal grant with rotation on wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_ff <= LAST_RST; // R11
    end else if (take_lo && ctrl_ff[ROT_EN_BIT]) begin
      last_ff <= arb_bus.norm_vec; // R10
    end else if (wr_hit && awaddr_ff[3:2] == REG_LAST_IDX) begin
      last_ff <= wdata_ff; // R10
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hivec_ff <= HIVEC_RST; // R20
    end else if (wr_hit && awaddr_ff[3:2] == REG_HIVEC_IDX) begin
      hivec_ff <= wdata_ff; // R1
    end
  end

  // ----------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------
  // vector 0 matches no source, so a zero register disables the level
  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_hisel
      assign hi_sel[g] = (hivec_ff == 8'(g + 1)); // R1 R20
    end
  endgenerate

  // non-maskable lines come from a build parameter, not a register
  assign arb_bus.nmi_req  = irq_req & NMI_MASK; // R6
  assign arb_bus.norm_req = irq_req & ~NMI_MASK & ~hi_sel;
  assign arb_bus.rot_en   = ctrl_ff[ROT_EN_BIT]; // R8
  assign arb_bus.last_vec = last_ff;
  assign hi_req           = |(irq_req & ~NMI_MASK & hi_sel);

  cipc_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
    .arb (arb_bus)
  );

  // ----------------------------------------------------------------
  // grant decision
  // ----------------------------------------------------------------
  // the global enable is only read here, never driven
  assign can_take = !holdoff_ff && !handler_return && !nmi_ex_ff; // R4 R21 R22
  assign take_nmi = can_take && arb_bus.nmi_hit; // R3
  assign take_hi  = can_take && !arb_bus.nmi_hit && global_int_enable
                    && !hi_ex_ff && hi_req; // R2
  assign take_lo  = can_take && !arb_bus.nmi_hit && global_int_enable
                    && !hi_ex_ff && !lo_ex_ff && !hi_req
                    && arb_bus.norm_hit; // R7 R9

  // one instruction must retire after every grant or return
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      holdoff_ff <= 1'b0;
    end else if (take_nmi || take_hi || take_lo || handler_return) begin
      holdoff_ff <= 1'b1; // R21
    end else if (insn_done) begin
      holdoff_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // executing flags
  // ----------------------------------------------------------------
  // a return ends the innermost handler, which is the highest flag
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      nmi_ex_ff <= 1'b0;
    end else if (take_nmi) begin
      nmi_ex_ff <= 1'b1; // R17
    end else if (handler_return) begin
      nmi_ex_ff <= 1'b0; // R17 R23
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hi_ex_ff <= 1'b0;
    end else if (take_hi) begin
      hi_ex_ff <= 1'b1; // R18
    end else if (handler_return && !nmi_ex_ff) begin
      hi_ex_ff <= 1'b0; // R18 R23
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lo_ex_ff <= 1'b0;
    end else if (take_lo) begin
      lo_ex_ff <= 1'b1; // R19
    end else if (handler_return && !nmi_ex_ff && !hi_ex_ff) begin
      lo_ex_ff <= 1'b0; // R2 R19 R23
    end
  end

  // ----------------------------------------------------------------
  // vector to the core
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_ack_ff <= 1'b0;
    end else begin
      irq_ack_ff <= take_nmi || take_hi || take_lo; // R23
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_vector_ff <= 8'h00;
    end else if (take_nmi) begin
      irq_vector_ff <= ctrl_ff[COMPACT_BIT] ? CVEC_NMI : arb_bus.nmi_vec; // R12
    end else if (take_hi) begin
      irq_vector_ff <= ctrl_ff[COMPACT_BIT] ? CVEC_HI : hivec_ff; // R12
    end else if (take_lo) begin
      irq_vector_ff <= ctrl_ff[COMPACT_BIT] ? CVEC_LO : arb_bus.norm_vec; // R12
    end
  end

  // the core adds this region base to every vector it fetches
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vector_region_select_ff <= 1'b0;
    end else begin
      vector_region_select_ff <= ctrl_ff[REGION_SEL_BIT]; // R13
    end
  end

endmodule

/* File: tb/cipc_properties.sv */
// port checker for the interrupt priority controller
// assumes it is bound into cipc_top and sees only its ports
`timescale 1ns/10ps
module cipc_properties #(
  parameter int                 NUM_SRC  = 16,
  parameter logic [NUM_SRC-1:0] NMI_MASK = '0,
  parameter int                 ADDR_W   = 8
) (
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic [NUM_SRC-1:0] irq_req,
  input wire logic               global_int_enable,
  input wire logic               insn_done,
  input wire logic               handler_return,
  input wire logic               irq_ack_ff,
  input wire logic [7:0]         irq_vector_ff,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic [ADDR_W-1:0]  s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp
);
  import cipc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_grant_gap; irq_ack_ff && !insn_done |=> !irq_ack_ff; endproperty
  a_grant_gap: assert property (p_grant_gap) else $error("grants too close");
  property p_ret_gap; handler_return |=> !irq_ack_ff; endproperty
  a_ret_gap: assert property (p_ret_gap) else $error("grant beside a return");
  property p_gie; irq_ack_ff && !$past(global_int_enable) |-> $past(|(irq_req & NMI_MASK));
  endproperty
  a_gie: assert property (p_gie) else $error("maskable grant while disabled");
  property p_req; irq_ack_ff |-> $past(|irq_req); endproperty
  a_req: assert property (p_req) else $error("grant without request");
  property p_nmi_first; irq_ack_ff && $past(irq_req[0]) && NMI_MASK[0] |-> irq_vector_ff == 8'h01;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("lowest nonmaskable lost");
  property p_wr_resp; s_wr_taken |-> ##[1:3] s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  property p_rd_resp; s_rd_taken |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
  property p_decerr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= ADDR_W'('h10)
      |=> s_axi_rresp == AXI_DECERR && s_axi_rdata == '0;
  endproperty
  a_decerr: assert property (p_decerr) else $error("unmapped read answered");
endmodule
bind cipc_top cipc_properties #(.NUM_SRC(NUM_SRC), .NMI_MASK(NMI_MASK), .ADDR_W(ADDR_W))
  cipc_properties_i (.mclk, .rst_n, .irq_req, .global_int_enable, .insn_done,
  .handler_return, .irq_ack_ff, .irq_vector_ff, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);

/* File: tb/cipc_core_model.sv */
// behavioural processor core that completes instructions and returns
// assumes the bench calls do_ret and do_unlock and sets run and gap
`timescale 1ns/10ps
module cipc_core_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] gap,
  output logic            insn_done,
  output logic            handler_return,
  output logic            change_protection_unlock
);
  logic [1:0] cnt_ff;
  initial begin
    handler_return = 1'b0;
    change_protection_unlock = 1'b0;
  end
  // stalls when run is low so an unlock window can be held open
  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      cnt_ff <= gap;
      insn_done <= 1'b0;
    end else begin
      insn_done <= (cnt_ff == 2'h0);
      cnt_ff <= (cnt_ff == 2'h0) ? gap : cnt_ff - 2'h1;
    end
  end
  task automatic do_ret();
    @(posedge mclk);
    handler_return <= 1'b1;
    @(posedge mclk);
    handler_return <= 1'b0;
  endtask
  task automatic do_unlock();
    @(posedge mclk);
    change_protection_unlock <= 1'b1;
    @(posedge mclk);
    change_protection_unlock <= 1'b0;
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the interrupt priority controller
// assumes the core model partner and the bound port checker
`timescale 1ns/10ps
module tb;
  import cipc_pkg::*;
  localparam logic [15:0] NMI_M = 16'h0003;
  logic        mclk, rst_n, global_int_enable, run, insn_done, handler_return, rot;
  logic        change_protection_unlock, irq_ack_ff, vector_region_select_ff;
  logic [15:0] irq_req, req;
  logic [7:0]  irq_vector_ff, s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gap;
  int          n_errors, check_count, ev, k, mreg[4];

  cipc_top #(.NUM_SRC(16), .NMI_MASK(NMI_M), .ADDR_W(8)) cipc_top_i (
    .mclk, .rst_n, .irq_req, .global_int_enable, .insn_done, .handler_return,
    .change_protection_unlock, .irq_ack_ff, .irq_vector_ff, .vector_region_select_ff,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  cipc_core_model cipc_core_model_i (
    .mclk, .rst_n, .run, .gap, .insn_done, .handler_return, .change_protection_unlock);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  // ----------------------------------------
  // bus, grant and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // the model mirrors the protected bits only when the write sits in a window
  task automatic wr(input int idx, input logic [31:0] d, input bit ccp);
    @(posedge mclk);
    s_axi_awaddr <= 8'(idx * 4);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge mclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, AXI_OKAY);
    if (idx == 0) mreg[0] = ccp ? (d & 32'h61) : ((mreg[0] & 32'h60) | (d & 32'h1));
    else if (idx > 1) mreg[idx] = d & 32'hFF;
  endtask
  task automatic rd(input int idx, input int exp);
    @(posedge mclk);
    s_axi_araddr <= 8'(idx * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, (idx > 3) ? AXI_DECERR : AXI_OKAY);
  endtask
  task automatic grant(input logic [15:0] r, input int exp);
    @(posedge mclk);
    irq_req <= r;
    do @(posedge mclk); while (irq_ack_ff !== 1'b1);
    irq_req <= '0;
    chk(irq_vector_ff, exp);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    mreg = '{default: 0};
    repeat (2) @(posedge mclk);
  endtask
  function automatic int pick(logic [15:0] r, bit rr, int last);
    int v;
    for (int i = 1; i <= 16; i++) begin
      v = rr ? (last + i - 1) % 16 + 1 : i;
      if (r[v-1]) return v;
    end
    return 0;
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(99382));
    {rst_n, global_int_enable, irq_req, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    run = 1'b1;
    gap = 2'h1;
    do_reset();
    for (int i = 0; i < 4; i++) rd(i, 0);
    rd(4, 0);
    wr(1, 32'hFF, 1'b0);
    rd(1, 0);
    wr(2, 32'hA5, 1'b0);
    rd(2, mreg[2]);
    wr(3, 32'h00, 1'b0);
    wr(0, 32'h61, 1'b0);
    rd(0, mreg[0]);
    run <= 1'b0;
    cipc_core_model_i.do_unlock();
    wr(0, 32'h60, 1'b1);
    run <= 1'b1;
    rd(0, mreg[0]);
    chk(vector_region_select_ff, 1);
    cipc_core_model_i.do_unlock();
    repeat (12) @(posedge mclk);
    wr(0, 32'h00, 1'b0);
    rd(0, mreg[0]);
    run <= 1'b0;
    cipc_core_model_i.do_unlock();
    wr(0, 32'h00, 1'b1);
    run <= 1'b1;
    @(posedge mclk);
    chk(vector_region_select_ff, 0);
    global_int_enable <= 1'b1;
    for (int n = 0; n < 12; n++) begin
      rot = 1'($urandom_range(1));
      req = (16'($urandom) | 16'h0008) & ~NMI_M;
      gap <= 2'($urandom_range(3, 1));
      wr(0, 32'(rot), 1'b0);
      wr(2, 32'($urandom_range(16)), 1'b0);
      ev = pick(req, rot, mreg[2]);
      grant(req, ev);
      rd(1, 1);
      if (rot) rd(2, ev);
      cipc_core_model_i.do_ret();
      rd(1, 0);
    end
    wr(0, 32'h00, 1'b0);
    wr(3, 32'h06, 1'b0);
    grant(16'h0008, 4);
    grant(16'h0020, 6);
    rd(1, 32'h03);
    grant(16'h0011, 1);
    rd(1, 32'h83);
    irq_req <= 16'h0002;
    k = 0;
    repeat (10) begin
      @(posedge mclk);
      if (irq_ack_ff === 1'b1) k++;
    end
    chk(k, 0);
    cipc_core_model_i.do_ret();
    grant(16'h0002, 2);
    rd(1, 32'h83);
    cipc_core_model_i.do_ret();
    rd(1, 32'h03);
    cipc_core_model_i.do_ret();
    rd(1, 32'h01);
    cipc_core_model_i.do_ret();
    rd(1, 0);
    global_int_enable <= 1'b0;
    grant(16'h0103, 1);
    cipc_core_model_i.do_ret();
    grant(16'h0102, 2);
    cipc_core_model_i.do_ret();
    rd(1, 0);
    run <= 1'b0;
    cipc_core_model_i.do_unlock();
    wr(0, 32'h20, 1'b1);
    run <= 1'b1;
    rd(0, mreg[0]);
    global_int_enable <= 1'b1;
    grant(16'h0100, 3);
    grant(16'h0020, 2);
    grant(16'h0002, 1);
    repeat (3) cipc_core_model_i.do_ret();
    rd(1, 0);
    @(posedge mclk);
    do_reset();
    rd(0, 0);
    rd(2, 0);
    wr(0, 32'h01, 1'b0);
    grant(16'h0408, 4);
    cipc_core_model_i.do_ret();
    print_verdict();
  end
endmodule
